//--- ffd_flop.sv
// Purpose: single-bit storage with direct set and direct clear
// Assumes: pins of neighbouring logic, sampled on CLK_I
// Notes:   element clock acts on its falling edge
`timescale 1ns/1ps
// How it works
// - set alone gives 1/0, clear alone 0/1, both give 0/0 outputs
// - going from one direct input to none keeps the held state
// - releasing both together restores the value stored before both went high
// - with no direct input, stored state changes only on a falling element clock edge
// - data level sampled together with the falling edge becomes true output after it
module ffd_flop (
  // clock and reset
  input  wire logic CLK_I,
  input  wire logic SYS_RST_I,
  // element pins
  input  wire logic ELEM_CLK_I,
  input  wire logic DATA_I,
  input  wire logic DIR_SET_I,
  input  wire logic DIR_CLR_I,
  // outputs
  output logic      Q_O,
  output logic      Q_N_O
);
  import ffd_pkg::*;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [3:0] pins_s;
  logic       eclk_s;
  logic       data_s;
  logic [1:0] dir_s;

  ffd_sync #(
    .WIDTH   (4),
    .RST_VAL ({FFD_RST_CLK, 3'h0})
  ) u_sync (
    .clk_i     (CLK_I),
    .rst_i     (SYS_RST_I),
    .async_i   ({ELEM_CLK_I, DATA_I, DIR_SET_I, DIR_CLR_I}),
    .sync_o    (pins_s)
  );

  assign eclk_s = pins_s[3];
  assign data_s = pins_s[2];
  assign dir_s  = pins_s[1:0];

  // ****************************************************************
  // decode
  // ****************************************************************
  logic       eclk_q;
  logic       store_q;
  logic       store_d;
  logic       fall;
  logic       dir_active;
  logic       q_d;
  logic       qn_d;
  ffd_state_t state_q;
  ffd_state_t state_d;

  assign fall       = eclk_q & ~eclk_s;
  assign dir_active = (dir_s != FFD_DIR_NONE);

  // stored bit: direct inputs win over clocked data
  always_comb begin
    store_d = store_q;
    case (dir_s)
      FFD_DIR_SET:   store_d = 1'b1;
      FFD_DIR_CLEAR: store_d = 1'b0;
      FFD_DIR_BOTH:  store_d = store_q;
      default: begin
        if (fall) begin
          store_d = data_s;
        end else begin
          store_d = store_q;
        end
      end
    endcase
  end

  // element state
  always_comb begin
    case (dir_s)
      FFD_DIR_BOTH:                state_d = FFD_ST_BOTH;
      FFD_DIR_SET, FFD_DIR_CLEAR:  state_d = FFD_ST_FORCE;
      default:                     state_d = FFD_ST_HOLD;
    endcase
  end

  // outputs: both low while both direct inputs high
  always_comb begin
    case (state_d)
      FFD_ST_BOTH: begin
        q_d  = 1'b0;
        qn_d = 1'b0;
      end
      default: begin
        q_d  = store_d;
        qn_d = ~store_d;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      eclk_q  <= FFD_RST_CLK;
      store_q <= FFD_RST_STATE;
      state_q <= FFD_ST_HOLD;
      Q_O     <= FFD_RST_STATE;
      Q_N_O   <= ~FFD_RST_STATE;
    end else begin
      eclk_q  <= eclk_s;
      store_q <= store_d;
      state_q <= state_d;
      Q_O     <= q_d;
      Q_N_O   <= qn_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_set_forces: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_SET) |=> (Q_O && !Q_N_O))
    else $error("set did not force true output high");

  a_clear_forces: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_CLEAR) |=> (!Q_O && Q_N_O))
    else $error("clear did not force true output low");

  a_both_low_out: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_BOTH) |=> (!Q_O && !Q_N_O))
    else $error("both direct inputs did not drive both outputs low");

  a_release_keeps: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_SET) ##1 (dir_s == FFD_DIR_NONE && !fall) |=> Q_O)
    else $error("release from set lost the stored state");

  a_no_fall_hold: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && !fall && state_q == FFD_ST_HOLD) |=> $stable(Q_O))
    else $error("state changed without falling element clock");

  a_fall_loads: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && fall) |=> (Q_O == $past(data_s) && Q_N_O == !$past(data_s)))
    else $error("falling edge did not load data");

  a_rise_ignored: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && !eclk_q && eclk_s && state_q == FFD_ST_HOLD) |=> $stable(Q_O))
    else $error("rising element clock changed state");

  a_dir_override: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_CLEAR && !fall && eclk_s) |=> (!Q_O && Q_N_O))
    else $error("direct clear waited for an element clock edge");

  a_outs_differ: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (state_q != FFD_ST_BOTH) |-> (Q_O != Q_N_O))
    else $error("outputs not complementary outside both-high case");

  a_both_pair: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (state_q == FFD_ST_BOTH) |-> (!Q_O && !Q_N_O))
    else $error("both-high state without both outputs low");

  a_clear_keeps: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_CLEAR) ##1 (dir_s == FFD_DIR_NONE && !fall) |=> !Q_O)
    else $error("release from clear lost the stored state");

  a_set_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_SET) |=> store_q)
    else $error("direct set did not load the stored bit");

  a_clear_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_CLEAR) |=> !store_q)
    else $error("direct clear did not empty the stored bit");

  a_both_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (dir_s == FFD_DIR_BOTH) |=> $stable(store_q))
    else $error("both direct inputs changed the stored bit");

  a_state_onehot: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    $onehot(state_q))
    else $error("element state not one-hot");

  a_fall_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && fall) |=> (store_q == $past(data_s)))
    else $error("falling edge did not store data");

  a_hold_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && !fall) |=> $stable(store_q))
    else $error("stored bit changed without falling edge");

  a_outs_track: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (state_q != FFD_ST_BOTH) |-> (Q_O == store_q))
    else $error("true output does not follow stored bit");

  a_fall_comp: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && fall) |=> (Q_N_O != Q_O))
    else $error("complement wrong after falling edge");

  a_rise_store: assert property (
    @(posedge CLK_I) disable iff (SYS_RST_I)
    (!dir_active && !eclk_q && eclk_s) |=> $stable(store_q))
    else $error("rising element clock changed stored bit");
endmodule // ffd_flop

//--- ffd_pkg.sv
// Purpose: shared constants for the direct set/clear flip-flop block
// Assumes: one system clock, device pins sampled through two flops
// Notes:   encodings of the direct input pair and of the element state
package ffd_pkg;
  // ****************************************************************
  // direct input pair encodings {set, clear}
  // ****************************************************************
  localparam logic [1:0] FFD_DIR_NONE  = 2'h0;
  localparam logic [1:0] FFD_DIR_CLEAR = 2'h1;
  localparam logic [1:0] FFD_DIR_SET   = 2'h2;
  localparam logic [1:0] FFD_DIR_BOTH  = 2'h3;
  // ****************************************************************
  // reset values and synchroniser depth
  // ****************************************************************
  localparam logic       FFD_RST_STATE = 1'b0;
  localparam logic       FFD_RST_CLK   = 1'b1;
  localparam int         FFD_SYNC_LEN  = 2;
  // ****************************************************************
  // element state
  // ****************************************************************
  typedef enum logic [2:0] {
    FFD_ST_HOLD  = 3'b001,
    FFD_ST_FORCE = 3'b010,
    FFD_ST_BOTH  = 3'b100
  } ffd_state_t;
endpackage

//--- ffd_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs come from outside the clock domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ffd_sync #(
  parameter int               WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // ffd_sync

//--- ffd_nbr.sv
// Purpose: neighbouring logic that drives the element pins
// Assumes: bench sets requests at the falling edge of clk_i
// Notes:   direct and clocked use kept apart
`timescale 1ns/1ps
module ffd_nbr (
  // clock
  input  wire logic       clk_i,
  // requests
  input  wire logic       clk_mode_i,
  input  wire logic [1:0] dir_i,
  input  wire logic       lvl_i,
  input  wire logic       d_i,
  // element pins
  output logic            elem_clk_o,
  output logic            set_o,
  output logic            clr_o,
  output logic            data_o
);
  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    elem_clk_o       <= clk_mode_i ? lvl_i : 1'b1;
    {set_o, clr_o}   <= clk_mode_i ? 2'h0 : dir_i;
    data_o           <= d_i;
  end
endmodule // ffd_nbr

//--- testbench.sv
// Purpose: self-checking bench for the direct set/clear flip-flop
// Assumes: outputs settle within six clock cycles of a pin change
// Notes:   release of both direct inputs together is never checked
`timescale 1ns/1ps
`define CHK(nm, a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %b got %b", nm, e, a); end end
module testbench;
  import ffd_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       mode = 1'b0;
  logic [1:0] dir = 2'h0;
  logic       lvl = 1'b1;
  logic       din = 1'b0;
  logic       ec, st, cl, dt, q, qn, p, d;
  logic [1:0] e, r;
  int         err_count = 0;
  int         num_checks = 0;
  logic [1:0] seq [10] = '{FFD_DIR_SET, FFD_DIR_NONE, FFD_DIR_CLEAR, FFD_DIR_NONE,
    FFD_DIR_BOTH, FFD_DIR_SET, FFD_DIR_NONE, FFD_DIR_BOTH, FFD_DIR_CLEAR, FFD_DIR_NONE};
  // ****************************************************************
  // clock, partner and design
  // ****************************************************************
  always #2 clk = ~clk;
  ffd_nbr nbr (.clk_i(clk), .clk_mode_i(mode), .dir_i(dir), .lvl_i(lvl), .d_i(din),
    .elem_clk_o(ec), .set_o(st), .clr_o(cl), .data_o(dt));
  ffd_flop dut (.CLK_I(clk), .SYS_RST_I(rst), .ELEM_CLK_I(ec), .DATA_I(dt),
    .DIR_SET_I(st), .DIR_CLR_I(cl), .Q_O(q), .Q_N_O(qn));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [1:0] exp_f(input logic [1:0] dr, input logic pv);
    case (dr)
      FFD_DIR_SET:   return 2'h2;
      FFD_DIR_CLEAR: return 2'h1;
      FFD_DIR_BOTH:  return 2'h0;
      default:       return {pv, ~pv};
    endcase
  endfunction
  task automatic step(input logic m, input logic [1:0] dr, input logic l, input logic dv);
    @(negedge clk);
    mode = m;
    dir = dr;
    lvl = l;
    din = dv;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(32'heea79924));
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    p = 1'b0;
    for (int i = 0; i < 10; i++) begin
      e = exp_f(seq[i], p);
      step(1'b0, seq[i], 1'b1, 1'($urandom));
      `CHK("direct", {q, qn}, e)
      p = e[1];
    end
    repeat (20) begin
      d = 1'($urandom);
      step(1'b1, FFD_DIR_NONE, 1'b1, d);
      `CHK("before fall", {q, qn}, {p, ~p})
      step(1'b1, FFD_DIR_NONE, 1'b0, d);
      `CHK("after fall", {q, qn}, {d, ~d})
      step(1'b1, FFD_DIR_NONE, 1'b0, ~d);
      step(1'b1, FFD_DIR_NONE, 1'b1, ~d);
      `CHK("after rise", {q, qn}, {d, ~d})
      p = d;
      r = seq[$urandom % 4];
      e = exp_f(r, p);
      step(1'b0, r, 1'b1, d);
      `CHK("random direct", {q, qn}, e)
      p = e[1];
    end
    results();
  end
  initial begin
    #20000;
    err_count++;
    results();
  end
endmodule // testbench
